// ### design/csa_map.svh
// Constants of the stall alarm: counts and codes.
// Assumes inclusion by bare name from the design files.
`ifndef CSA_MAP_SVH
`define CSA_MAP_SVH
`define CSA_STALL_LIMIT      8'h80
`define CSA_CNT_ZERO         8'h00
`define CSA_CNT_ONE          8'h01
`define CSA_TRAP_GROUP       2'h0
`define CSA_TRAP_LEVEL       5'h05
`define CSA_KEY_LOCK         2'h2
`define CSA_LOCKOUT_CYCLES   2'h1
`endif

// ### design/csa_pkg.sv
// Types shared by the stall alarm files.
// Assumes csa_map.svh supplies numeric constants.
package csa_pkg;
  typedef enum logic [3:0] {
    CSA_IDLE  = 4'b0001,
    CSA_COUNT = 4'b0010,
    CSA_DRAIN = 4'b0100,
    CSA_TRAP  = 4'b1000
  } csa_state_type;

  // Per-cycle view of the CPU
  typedef struct packed {
    logic       cycle_active;
    logic       monitored_instr;
    logic       instr_done;
    logic       execute_memory_instr;
    logic       indirect_cycle;
    logic       halted;
    logic       at_boundary;
    logic       dma_mem_write;
    logic       dma_cycle_done;
  } csa_cpu_type;

  // Controls returned to the CPU
  typedef struct packed {
    logic       trap_req;
    logic [1:0] trap_group;
    logic [4:0] trap_level;
    logic       terminate_op;
    logic       abort_chain;
    logic       force_run;
    logic       irq_block;
  } csa_ctl_type;
endpackage

// ### design/csa_stall_counter.sv
// Saturating stall cycle counter.
// Assumes clear and advance come from the alarm top.
`timescale 1ns/1ns
`include "csa_map.svh"
module csa_stall_counter (
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       clear,
  input  wire logic       advance,
  output logic [7:0]      count,
  output logic            expired
);
  typedef struct packed {
    logic [7:0] cnt;
  } csa_cnt_state_type;

  csa_cnt_state_type st_q;
  csa_cnt_state_type st_d;

  always_comb
  begin
    st_d = st_q;
    if (clear)
    begin
      st_d.cnt = `CSA_CNT_ZERO;
    end
    // Saturate so a long stall cannot wrap
    else if (advance && (st_q.cnt != `CSA_STALL_LIMIT))
    begin
      st_d.cnt = st_q.cnt + `CSA_CNT_ONE;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign count   = st_q.cnt;
  assign expired = (st_q.cnt == `CSA_STALL_LIMIT);
endmodule

// ### design/csa_stall_alarm.sv
// Stall watchdog beside the CPU sequencer.
// Assumes cpu inputs synchronous to ref_clk, one sample per clock.
// Overview of operation
// [RULE_01] Armed only while key switch reports the locked panel position. Code still traps from CSA_DRAIN after the key leaves lock.
// [RULE_02] While armed, monitored instruction or condition starts the stall counter.
// [RULE_03] Counter advances each active CPU cycle while condition persists.
// [RULE_04] Condition still present after 128 cycles requests trap group 0 level 5.
// [RULE_05] Monitored set covers I/O, paging, interrupt control, stack, save, execute-memory.
// [RULE_06] Halt and indirect memory cycles also start the counter.
// [RULE_07] External interrupts refused one cycle after a monitored instruction completes.
// [RULE_08] Back-to-back monitored instructions keep interrupts locked out throughout.
// [RULE_09] Interrupts taken only on instruction boundaries, deferring indirect chains.
// [RULE_10] A halted CPU recognises no external interrupts.
// [RULE_11] Power failure disables the alarm; restoration re-enables it. Code still traps from CSA_DRAIN after power loss.
// [RULE_12] Raising the trap terminates the stalled monitored operation.
// [RULE_13] Execute-memory or indirect chains are aborted by the alarm itself.
// [RULE_14] A block channel memory write finishes its cycle before termination.
// [RULE_15] A halted CPU is forced into run mode when the trap is raised.
// [RULE_16] Counter clears to zero whenever nothing monitored is active.
`timescale 1ns/1ns
`include "csa_map.svh"
module csa_stall_alarm (
  input  wire logic                ref_clk,
  input  wire logic                rst,
  input  wire logic [1:0]          key_position,
  input  wire logic                power_ok,
  input  wire csa_pkg::csa_cpu_type cpu,
  output csa_pkg::csa_ctl_type     ctl,
  output logic [7:0]               stall_count
);
  typedef struct packed {
    csa_pkg::csa_state_type state;
    logic                   lockout;
    csa_pkg::csa_ctl_type   ctl;
    logic [7:0]             count_out;
  } csa_top_state_type;

  csa_top_state_type st_q;
  csa_top_state_type st_d;

  logic       armed;
  logic       watched;
  logic       cnt_clear;
  logic       cnt_advance;
  logic [7:0] cnt_value;
  logic       cnt_expired;
  logic       chain_active;

  // Key lock and power
  assign armed = (key_position == `CSA_KEY_LOCK) && power_ok;

  // Decoded instruction class plus halt and indirect
  assign watched = cpu.monitored_instr || cpu.execute_memory_instr
                   || cpu.halted || cpu.indirect_cycle;

  assign chain_active = cpu.execute_memory_instr || cpu.indirect_cycle;

  // [RULE_16] Zero when idle
  assign cnt_clear = !armed || !watched || (st_q.state == csa_pkg::CSA_TRAP);

  // Active cycles only
  assign cnt_advance = armed && watched && cpu.cycle_active;

  csa_stall_counter u_counter (
    .ref_clk (ref_clk),
    .rst     (rst),
    .clear   (cnt_clear),
    .advance (cnt_advance),
    .count   (cnt_value),
    .expired (cnt_expired)
  );

  always_comb
  begin
    st_d                  = st_q;
    st_d.count_out        = cnt_value;
    st_d.ctl.trap_req     = 1'b0;
    st_d.ctl.terminate_op = 1'b0;
    st_d.ctl.abort_chain  = 1'b0;
    st_d.ctl.force_run    = 1'b0;
    st_d.ctl.trap_group   = `CSA_TRAP_GROUP;
    st_d.ctl.trap_level   = `CSA_TRAP_LEVEL;

    // [RULE_07] Lockout after completion
    // [RULE_08] Renewed by each completion
    st_d.lockout = cpu.instr_done && (cpu.monitored_instr || cpu.execute_memory_instr);

    // [RULE_09] Boundary gating
    // [RULE_10] Halt blocks interrupts
    st_d.ctl.irq_block = st_d.lockout || !cpu.at_boundary || cpu.halted;

    case (st_q.state)
      csa_pkg::CSA_IDLE:
      begin
        // [RULE_02] Start counting
        // [RULE_05] Monitored instruction set
        // [RULE_06] Halt or indirect
        if (armed && watched)
        begin
          st_d.state = csa_pkg::CSA_COUNT;
        end
      end
      csa_pkg::CSA_COUNT:
      begin
        // [RULE_01] Disarm on key
        // [RULE_11] Power loss disables
        // [RULE_16] Condition removed
        if (!armed || !watched)
        begin
          st_d.state = csa_pkg::CSA_IDLE;
        end
        // [RULE_03] Counted to limit
        else if (cnt_expired)
        begin
          // [RULE_14] Let channel finish
          if (cpu.dma_mem_write && !cpu.dma_cycle_done)
          begin
            st_d.state = csa_pkg::CSA_DRAIN;
          end
          else
          begin
            st_d.state = csa_pkg::CSA_TRAP;
          end
        end
      end
      csa_pkg::CSA_DRAIN:
      begin
        // Channel cycle must close even if stall lifts
        if (!cpu.dma_mem_write || cpu.dma_cycle_done)
        begin
          st_d.state = csa_pkg::CSA_TRAP;
        end
      end
      csa_pkg::CSA_TRAP:
      begin
        // [RULE_04] Trap request
        st_d.ctl.trap_req     = 1'b1;
        // [RULE_12] Terminate operation
        st_d.ctl.terminate_op = 1'b1;
        // [RULE_13] Abort chains
        st_d.ctl.abort_chain  = chain_active;
        // [RULE_15] Force run
        st_d.ctl.force_run    = cpu.halted;
        st_d.state            = csa_pkg::CSA_IDLE;
      end
      default:
      begin
        st_d.state = csa_pkg::CSA_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      st_q       <= '0;
      st_q.state <= csa_pkg::CSA_IDLE;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign ctl         = st_q.ctl;
  assign stall_count = st_q.count_out;
endmodule

// ### testbench/csa_alarm_chk.sv
// Port checker for the stall alarm.
// Assumes a bind onto csa_stall_alarm.
`timescale 1ns/1ns
module csa_alarm_chk (
  input wire logic                 ref_clk,
  input wire logic                 rst,
  input wire logic [1:0]           key_position,
  input wire logic                 power_ok,
  input wire csa_pkg::csa_cpu_type cpu,
  input wire csa_pkg::csa_ctl_type ctl,
  input wire logic [7:0]           stall_count
);
  default clocking dcb @(posedge ref_clk); endclocking
  default disable iff (rst);
  chk_trap_pulse: assert property (ctl.trap_req |=> !ctl.trap_req) else $error("long trap");
  chk_trap_code:
    assert property (ctl.trap_req |-> ctl.trap_group == 2'h0 && ctl.trap_level == 5'h05) else $error("trap code");
  chk_trap_ends: assert property (ctl.terminate_op == ctl.trap_req) else $error("no end");
  chk_chain_abort:
    assert property (ctl.trap_req && cpu.execute_memory_instr |-> ctl.abort_chain) else $error("no abort");
  chk_force_run: assert property (ctl.trap_req && cpu.halted |-> ctl.force_run) else $error("no run");
  chk_irq_lockout:
    assert property (cpu.instr_done && cpu.monitored_instr |=> ctl.irq_block) else $error("no lockout");
  chk_key_idle: assert property (key_position != 2'h2 |=> ##1 stall_count == 8'h00) else $error("key");
  chk_power_idle: assert property (!power_ok |=> ##1 stall_count == 8'h00) else $error("power");
  cover property (ctl.abort_chain);
  cover property (ctl.force_run);
  cover property (ctl.trap_req && cpu.monitored_instr);
endmodule
bind csa_stall_alarm csa_alarm_chk csa_alarm_chk_inst (.*);

// ### testbench/csa_cpu_model.sv
// CPU stand-in holding one stalled condition.
// Assumes the bench picks the condition by kind.
`timescale 1ns/1ns
module csa_cpu_model (
  input  wire logic                 ref_clk,
  input  wire logic                 rst,
  input  wire logic [2:0]           kind,
  input  wire logic                 active,
  input  wire logic                 done,
  input  wire logic                 dma_busy,
  input  wire csa_pkg::csa_ctl_type ctl,
  output csa_pkg::csa_cpu_type      cpu
);
  logic gone_q;
  always_ff @(posedge ref_clk)
    gone_q <= !rst && kind != 3'h0 && (gone_q || ctl.terminate_op || ctl.force_run);
  always_comb
  begin
    cpu = '0;
    cpu.cycle_active = active;
    cpu.instr_done = done;
    // Channel write stays open until the bench lets it go
    cpu.dma_mem_write = dma_busy;
    // Kind 1..4: instruction, chain, indirect, halt
    {cpu.monitored_instr, cpu.execute_memory_instr, cpu.indirect_cycle, cpu.halted} = gone_q ? 4'h0 : 4'h8 >> (kind - 3'h1);
    cpu.at_boundary = kind == 3'h0 || gone_q;
  end
endmodule

// ### testbench/test_csa_stall_alarm.sv
// Bench for the stall alarm beside a CPU stand-in.
// Assumes the checker binds itself.
`timescale 1ns/1ns
module test_csa_stall_alarm;
  logic                 ref_clk = 1'b0, rst = 1'b1, power_ok = 1'b1, active = 1'b1, done = 1'b0;
  logic                 dma_busy = 1'b0;
  logic [1:0]           key_position = 2'h2;
  logic [2:0]           kind = 3'h0;
  logic [7:0]           stall_count;
  int                   n_errors = 0, total_checks = 0, cycles = 0;
  csa_pkg::csa_cpu_type cpu;
  csa_pkg::csa_ctl_type ctl;
  csa_cpu_model csa_cpu_model_inst (.*);
  csa_stall_alarm csa_stall_alarm_inst (.*);
  task automatic check(string what, logic [15:0] exp, logic [15:0] got);
    total_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic t_trap(logic [2:0] k, logic gap);
    int n;
    kind = k;
    for (n = 0; n < 300 && ctl.trap_req !== 1'b1; n++)
    begin
      @(negedge ref_clk);
      active = gap ? ~active : 1'b1;
    end
    active = 1'b1;
    check("delay", gap ? 16'h0101 : 16'h0082, n[15:0]);
    check("acts", {6'h01, k == 3'h2 || k == 3'h3, k == 3'h4},
      {5'h00, ctl.terminate_op, ctl.abort_chain, ctl.force_run});
    kind = 3'h0;
    @(negedge ref_clk);
    $display("trap test %0d done", k);
  endtask
  task automatic t_off(logic [1:0] key, logic pwr);
    logic bad;
    {key_position, power_ok, kind, done, bad} = {key, pwr, 3'h1, 1'b1, 1'b0};
    repeat (140)
    begin
      @(negedge ref_clk);
      bad = bad | ctl.trap_req | (|stall_count);
    end
    check("off", 8'h00, {7'h00, bad});
    check("block", 8'h01, {7'h00, ctl.irq_block});
    {key_position, power_ok, kind, done} = {2'h2, 1'b1, 3'h0, 1'b0};
    @(negedge ref_clk);
    $display("disarm test done");
  endtask
  task automatic t_drain;
    int seen;
    seen = 0;
    {kind, dma_busy} = {3'h1, 1'b1};
    repeat (140)
    begin
      @(negedge ref_clk);
      seen += ctl.trap_req;
    end
    check("drain hold", 16'h0000, seen[15:0]);
    dma_busy = 1'b0;
    repeat (2) @(negedge ref_clk);
    check("drain trap", 16'h0001, {15'h0000, ctl.trap_req});
    kind = 3'h0;
    @(negedge ref_clk);
    $display("drain test done");
  endtask
  initial
    forever #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk)
    if (++cycles > 4000)
    begin
      n_errors++;
      wrap_up();
    end
  initial
  begin
    repeat (3) @(negedge ref_clk);
    rst = 1'b0;
    @(negedge ref_clk);
    for (int k = 1; k < 5; k++)
      t_trap(k[2:0], 1'b0);
    t_trap(3'h2, 1'b1);
    t_drain();
    // Keys 0, 1, 3 powered, then lock with power down
    for (int k = 0; k < 4; k++)
      t_off(2'(8'hb4 >> (2 * k)), k != 3);
    t_trap(3'h1, 1'b0);
    wrap_up();
  end
endmodule
